// File: hw/arp_pkg.sv
package arp_pkg;
   // widths of the result word, the host bus and the channel address
   localparam int unsigned RES_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CH_W = 2;
   // field positions on the host data lines
   localparam int unsigned LO_MSB = 7;        // low byte carries result 7..0
   localparam int unsigned HI_LSB = 8;        // high byte carries result 11..8
   localparam int unsigned HI_MSB = 11;
   localparam int unsigned HI_LINE_MSB = 3;   // ...on lines 3..0
   localparam int unsigned ZERO_LSB = 4;      // lines 6..4 read low in the high byte
   localparam int unsigned ZERO_MSB = 6;
   localparam int unsigned STATUS_LINE = 7;   // converter status line in the high byte
   // values after reset
   localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
   localparam logic [DATA_W-1:0] DOUT_RST = 8'h00;
   localparam logic [CH_W-1:0] CHAN_RST = 2'h0;
   localparam logic [2:0] ZERO3 = 3'h0;

   // conversion phase, gray coded along idle -> convert -> idle
   typedef enum logic [1:0] {
      ARP_IDLE = 2'b00,
      ARP_CONV = 2'b01
   } arp_phase_t;

   // host side control pins, all sampled on clk
   typedef struct packed {
      logic cs_n;                         // chip select, active low
      logic rd_n;                         // read strobe, active low
      logic wr_n;                         // write strobe, active low
      logic high_byte_select;             // 1 selects the high byte
      logic special_function_select;      // level driven by the host
      logic special_function_driven;      // 0 when the pin is left open
      logic [CH_W-1:0] channel_address;   // channel for the next conversion
   } arp_host_ctl_t;

   // whole state of the port
   typedef struct packed {
      arp_phase_t phase;                  // idle or converting
      logic [RES_W-1:0] result;           // last completed result
      logic [CH_W-1:0] chan_hold;         // address seen during the write access
      logic wr_seen;                      // a write access was active last cycle
      logic special_sel_w; // special select seen in the last active write cycle
      logic conv_start;                   // one-cycle start pulse to the core
      logic [CH_W-1:0] conv_channel;      // channel handed to the core
      logic sfr_wr;                       // one-cycle write pulse to the special register
      logic [DATA_W-1:0] sfr_wdata;       // byte written to the special register
      logic [DATA_W-1:0] dout;            // registered data line value
      logic doe;                          // registered data line enable
   } arp_state_t;
endpackage

// File: hw/arp_read_port.sv
`timescale 1ns/1ps
module arp_read_port (
   input wire logic clk,
   input wire logic srst,
   input wire arp_pkg::arp_host_ctl_t host_ctl,
   input wire logic [arp_pkg::DATA_W-1:0] host_data_in,
   output logic [arp_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe,
   output logic busy_n,
   output logic conv_start,
   output logic [arp_pkg::CH_W-1:0] conv_channel,
   input wire logic core_done,
   input wire logic [arp_pkg::RES_W-1:0] core_result,
   input wire logic cal_active,
   input wire logic [arp_pkg::DATA_W-1:0] sfr_rd_data,
   output logic sfr_wr,
   output logic [arp_pkg::DATA_W-1:0] sfr_wdata
);

   ////////////////////////////////////////////////////////////////////////////
   // decode of the host strobes
   arp_pkg::arp_state_t st_r; // registered state
   arp_pkg::arp_state_t st_nxt; // next state
   logic sfs_eff; // special select after the pull-down
   logic rd_acc; // read access in progress
   logic wr_acc; // write access in progress
   logic conv_busy; // conversion or calibration running
   // strobes are sampled on clk, so an access must stand across at least one edge;
   // a strobe pulse shorter than a clock period may be missed altogether

   // an open pin reads as low, so plain result reads are the default
   assign sfs_eff = host_ctl.special_function_driven & host_ctl.special_function_select;
   // every access needs chip select together with a strobe
   assign rd_acc = ~host_ctl.cs_n & ~host_ctl.rd_n;
   assign wr_acc = ~host_ctl.cs_n & ~host_ctl.wr_n;
   assign conv_busy = (st_r.phase == arp_pkg::ARP_CONV) | cal_active;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.conv_start = 1'b0;
      st_nxt.sfr_wr = 1'b0;
      st_nxt.wr_seen = wr_acc;
      // address follows the pins during the write, committed at its end
      if (wr_acc) begin
         st_nxt.chan_hold = host_ctl.channel_address;
         st_nxt.sfr_wdata = host_data_in;
         st_nxt.special_sel_w = sfs_eff;
      end
      // phase machine; a start in the done cycle keeps the port converting
      case (st_r.phase)
         arp_pkg::ARP_IDLE: begin
            st_nxt.phase = arp_pkg::ARP_IDLE;
         end
         arp_pkg::ARP_CONV: begin
            // result is captured as the core reports completion
            if (core_done) begin
               st_nxt.phase = arp_pkg::ARP_IDLE;
               st_nxt.result = core_result;
            end
         end
         default: begin
            st_nxt.phase = arp_pkg::ARP_IDLE;
         end
      endcase
      // end of a write access: the rising strobe edge or chip select edge
      // acting on the end rather than the start lets the address settle during the access,
      // at the price of one more cycle before the core sees the start
      if (st_r.wr_seen && !wr_acc) begin
         if (st_r.special_sel_w) begin
            st_nxt.sfr_wr = 1'b1; // special register write, no conversion
         end else begin
            st_nxt.conv_start = 1'b1;
            st_nxt.conv_channel = st_r.chan_hold;
            st_nxt.phase = arp_pkg::ARP_CONV;
         end
      end
      // data lines: registered so they come from flip-flops, one cycle behind
      st_nxt.doe = rd_acc;
      if (!rd_acc) begin
         st_nxt.dout = arp_pkg::DOUT_RST; // released, value cleared to zero
      end else if (sfs_eff) begin
         st_nxt.dout = sfr_rd_data;
      end else if (host_ctl.high_byte_select) begin
         // status line, zero lines, then the top nibble of the result
         st_nxt.dout[arp_pkg::STATUS_LINE] = conv_busy;
         st_nxt.dout[arp_pkg::ZERO_MSB:arp_pkg::ZERO_LSB] = arp_pkg::ZERO3;
         st_nxt.dout[arp_pkg::HI_LINE_MSB:0] =
            st_r.result[arp_pkg::HI_MSB:arp_pkg::HI_LSB];
      end else begin
         st_nxt.dout = st_r.result[arp_pkg::LO_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r.phase <= arp_pkg::ARP_IDLE;
         st_r.result <= arp_pkg::RESULT_RST;
         st_r.chan_hold <= arp_pkg::CHAN_RST;
         st_r.wr_seen <= 1'b0;
         st_r.special_sel_w <= 1'b0; // a write after reset defaults to a conversion
         st_r.conv_start <= 1'b0;
         st_r.conv_channel <= arp_pkg::CHAN_RST;
         st_r.sfr_wr <= 1'b0;
         st_r.sfr_wdata <= arp_pkg::DOUT_RST;
         st_r.dout <= arp_pkg::DOUT_RST;
         st_r.doe <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // busy is combinational so calibration shows without a cycle of lag
   assign busy_n = ~conv_busy;
   assign host_data_out = st_r.dout;
   assign host_data_oe = st_r.doe;
   assign conv_start = st_r.conv_start;
   assign conv_channel = st_r.conv_channel;
   assign sfr_wr = st_r.sfr_wr;
   assign sfr_wdata = st_r.sfr_wdata;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // the data lines come from flip-flops, so every read check looks one cycle after
   // the access was sampled; a combinational bus would need these moved back a cycle
   // busy is combinational, so its checks look at the same cycle
   a_low_byte_map: assert property (@(posedge clk) disable iff (srst)
      rd_acc && !sfs_eff && !host_ctl.high_byte_select |=>
         host_data_oe && host_data_out == $past(st_r.result[7:0]))
      else $error("low byte not mapped to lines 7..0");

   a_high_nibble_map: assert property (@(posedge clk) disable iff (srst)
      rd_acc && !sfs_eff && host_ctl.high_byte_select |=>
         host_data_out[3:0] == $past(st_r.result[11:8]))
      else $error("high nibble not on lines 3..0");

   a_high_zero_lines: assert property (@(posedge clk) disable iff (srst)
      rd_acc && !sfs_eff && host_ctl.high_byte_select |=> host_data_out[6:4] == 3'h0)
      else $error("lines 6..4 not low in high byte");

   a_status_line: assert property (@(posedge clk) disable iff (srst)
      rd_acc && !sfs_eff && host_ctl.high_byte_select |=> host_data_out[7] == !$past(busy_n))
      else $error("status line is not inverted busy");

   a_special_route: assert property (@(posedge clk) disable iff (srst)
      rd_acc && sfs_eff |=> host_data_oe && host_data_out == $past(sfr_rd_data))
      else $error("special select did not route special register");

   a_open_pin_low: assert property (@(posedge clk) disable iff (srst)
      rd_acc && !host_ctl.special_function_driven && !host_ctl.high_byte_select |=>
         host_data_out == $past(st_r.result[7:0]))
      else $error("open special select pin not read as low");

   a_start_channel: assert property (@(posedge clk) disable iff (srst)
      wr_acc && !sfs_eff ##1 !wr_acc |=>
         conv_start && conv_channel == $past(host_ctl.channel_address, 2) ##1 !conv_start)
      else $error("write end did not start conversion on latched channel");

   a_busy_span: assert property (@(posedge clk) disable iff (srst)
      !busy_n && !cal_active && !core_done |=> !busy_n)
      else $error("busy rose before conversion done");

   a_busy_at_start: assert property (@(posedge clk) disable iff (srst)
      conv_start |-> !busy_n)
      else $error("busy not low as conversion starts");

   a_busy_release: assert property (@(posedge clk) disable iff (srst)
      core_done && !busy_n && !cal_active && st_r.phase == arp_pkg::ARP_CONV &&
         !(st_r.wr_seen && !wr_acc) ##1 !cal_active |-> busy_n && st_r.result == $past(core_result))
      else $error("busy not released or result not captured");

   a_bus_release: assert property (@(posedge clk) disable iff (srst)
      host_ctl.cs_n || host_ctl.rd_n |=> !host_data_oe)
      else $error("data lines driven outside a read");

   // released lines carry zero so a stale result never lingers in the flops
   a_release_value: assert property (@(posedge clk) disable iff (srst)
      !rd_acc |=> host_data_out == 8'h00)
      else $error("released data value not cleared");

   // a start is a single pulse
   a_start_single: assert property (@(posedge clk) disable iff (srst)
      conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");

   // a write with special select goes to the special register with its byte
   a_special_write: assert property (@(posedge clk) disable iff (srst)
      wr_acc && sfs_eff ##1 !wr_acc |=>
         sfr_wr && !conv_start && sfr_wdata == $past(host_data_in, 2))
      else $error("special register write not issued");

   // the special write is a single pulse
   a_special_single: assert property (@(posedge clk) disable iff (srst)
      sfr_wr |=> !sfr_wr)
      else $error("special register write longer than one cycle");

   // one write ends in either a start or a special write, never both
   a_pulse_exclusive: assert property (@(posedge clk) disable iff (srst)
      !(conv_start && sfr_wr))
      else $error("start and special write together");

   // reset leaves the bus released and no pulse pending
   a_reset_values: assert property (@(posedge clk)
      srst |=> !host_data_oe && !conv_start && !sfr_wr && conv_channel == 2'h0)
      else $error("outputs not at reset values");

endmodule

// File: test/arp_host_model.sv
`timescale 1ns/1ps
// host bus master: strobes change just after an edge and hold for a whole access
module arp_host_model (
   input wire logic clk,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   output arp_pkg::arp_host_ctl_t host_ctl,
   output logic [7:0] host_data_in
);
   logic [7:0] last_r = 8'h00; // last byte the device drove
   logic [7:0] wdata_r = 8'h00; // byte the host puts on the lines in a write
   logic wdrive_r = 1'b0; // host drives the lines during a write
   initial host_ctl = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
   ////////////////////////////////////////////////////////////////////////////
   // released lines must not keep the old value, so show its inverse
   always @(posedge clk) begin
      if (host_data_oe) last_r <= host_data_out;
   end
   assign host_data_in = host_data_oe ? host_data_out : (wdrive_r ? wdata_r : ~last_r);
   ////////////////////////////////////////////////////////////////////////////
   // read: strobes sampled at one edge, answer taken at the edge after
   task automatic rd(input logic hbs, input logic sfs, input logic drv, output logic [8:0] v);
      @(posedge clk);
      host_ctl.cs_n <= 1'b0;
      host_ctl.rd_n <= 1'b0;
      host_ctl.high_byte_select <= hbs;
      host_ctl.special_function_select <= sfs;
      host_ctl.special_function_driven <= drv;
      @(posedge clk);
      @(negedge clk);
      v = {host_data_oe, host_data_out};
      @(posedge clk);
      host_ctl.cs_n <= 1'b1;
      host_ctl.rd_n <= 1'b1;
   endtask
   // write: one active cycle, the start fires on the strobe's rising end
   task automatic wr(input logic [1:0] ch, input logic sfs, input logic [7:0] d);
      @(posedge clk);
      host_ctl.cs_n <= 1'b0;
      host_ctl.wr_n <= 1'b0;
      host_ctl.special_function_select <= sfs;
      host_ctl.special_function_driven <= sfs; // conversions leave the pin open
      host_ctl.channel_address <= ch;
      wdata_r <= d;
      wdrive_r <= 1'b1;
      @(posedge clk);
      host_ctl.cs_n <= 1'b1;
      host_ctl.wr_n <= 1'b1;
      wdrive_r <= 1'b0;
   endtask
endmodule

// File: test/arp_read_port_tb.sv
`timescale 1ns/1ps
module arp_read_port_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   arp_pkg::arp_host_ctl_t host_ctl;
   logic [7:0] dout, din, sfr_rd, sfr_wd;
   logic oe, busy_n, start, done, cal, sfr_wr;
   logic [1:0] chan;
   logic [11:0] res;
   logic [8:0] v; // {line enable, data byte} from one read
   int bad_count = 0;
   int n_compared = 0;
   initial forever #2 clk = ~clk;
   arp_host_model u_arp_host_model (.clk(clk), .host_data_out(dout), .host_data_oe(oe),
      .host_ctl(host_ctl), .host_data_in(din));
   arp_read_port u_arp_read_port (.clk(clk), .srst(srst), .host_ctl(host_ctl),
      .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .busy_n(busy_n),
      .conv_start(start), .conv_channel(chan), .core_done(done), .core_result(res),
      .cal_active(cal), .sfr_rd_data(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wd));
   ////////////////////////////////////////////////////////////////////////////
   // one compare for all results: flags are zero extended to nine bits
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // start on channel 2, read status mid conversion, then complete it
   task automatic t_conv;
      u_arp_host_model.wr(2'h2, 1'b0, 8'h00);
      @(posedge clk);
      @(negedge clk);
      chk("start", 9'h001, {8'h00, start});
      chk("channel", 9'h002, {7'h00, chan});
      chk("busy_n", 9'h000, {8'h00, busy_n});
      @(negedge clk);
      chk("start pulse", 9'h000, {8'h00, start});
      u_arp_host_model.rd(1'b1, 1'b0, 1'b1, v);
      chk("high busy", 9'h180, v);
      res <= 12'ha5c;
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(negedge clk);
      chk("busy_n", 9'h001, {8'h00, busy_n});
      $display("conversion test done");
   endtask
   // both bytes, the open special pin, the special register, then release
   task automatic t_reads;
      u_arp_host_model.rd(1'b0, 1'b0, 1'b1, v);
      chk("low", 9'h15c, v);
      u_arp_host_model.rd(1'b1, 1'b0, 1'b1, v);
      chk("high", 9'h10a, v);
      u_arp_host_model.rd(1'b0, 1'b1, 1'b0, v);
      chk("open pin", 9'h15c, v);
      u_arp_host_model.rd(1'b0, 1'b1, 1'b1, v);
      chk("special", {1'b1, sfr_rd}, v);
      @(posedge clk);
      @(negedge clk);
      chk("released", 9'h000, {oe, dout});
      $display("read test done");
   endtask
   // calibration alone must also show busy on both outputs
   task automatic t_cal;
      @(posedge clk);
      cal <= 1'b1;
      @(negedge clk);
      chk("cal busy_n", 9'h000, {8'h00, busy_n});
      u_arp_host_model.rd(1'b1, 1'b0, 1'b1, v);
      chk("cal high", 9'h18a, v);
      cal <= 1'b0;
      $display("calibration test done");
   endtask
   // special register write: byte handed over, no conversion, one-cycle pulse
   task automatic t_sfr;
      u_arp_host_model.wr(2'h3, 1'b1, 8'h5a);
      @(posedge clk);
      @(negedge clk);
      chk("sfr_wr", 9'h001, {8'h00, sfr_wr});
      chk("sfr_wdata", 9'h05a, {1'b0, sfr_wd});
      chk("no start", 9'h000, {8'h00, start});
      chk("sfr busy_n", 9'h001, {8'h00, busy_n});
      @(negedge clk);
      chk("sfr pulse", 9'h000, {8'h00, sfr_wr});
      $display("special write test done");
   endtask
   // reset in mid conversion: busy released, result cleared, read right after
   task automatic t_reset;
      u_arp_host_model.wr(2'h1, 1'b0, 8'h00);
      @(posedge clk);
      srst <= 1'b1;
      @(negedge clk);
      chk("busy before reset", 9'h000, {8'h00, busy_n});
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk("reset busy_n", 9'h001, {8'h00, busy_n});
      chk("reset channel", 9'h000, {7'h00, chan});
      u_arp_host_model.rd(1'b0, 1'b0, 1'b1, v);
      chk("reset low", 9'h100, v);
      $display("reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      done = 1'b0;
      cal = 1'b0;
      res = 12'h000;
      sfr_rd = 8'h3c;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_conv;
      t_reads;
      t_cal;
      t_sfr;
      t_reset;
      close_out;
   end
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (2000) @(posedge clk);
      bad_count++;
      $display("[FAIL] watchdog expected finish seen hang");
      close_out;
   end
endmodule
